// [rtl/prcs_pkg.sv]
// What this block does
// - Rx diff and low enable: limit low at low rate
// - Rx diff off: all packets use low rate
// - Low rx enable switches low rx limiting
// - Rx diff and high enable: limit high rate
// - High enable, no diff, low enable: all low
// - Low rate exceeded flow control only if enabled
// - High flow control needs enable and rx diff
// - Tx diff: each class against own counter
// - Tx diff off: all use low counter
// - Low tx enable switches low egress limiting
// - High tx enable switches high egress limiting
// - Rate limits are 12-bit block counts
package prcs_pkg;
  localparam int NUM_PORTS = 5;
  localparam int RATE_W    = 12;
  // Bus address width, wide enough for four times the largest index
  localparam int AXI_ADDR_W = 10;

  // Word indices of the per-port control registers, byte address is four times
  localparam logic [7:0] PORT1_RATE_LIMIT_CTRL_IDX = 8'h1B;
  localparam logic [7:0] PORT2_RATE_LIMIT_CTRL_IDX = 8'h2B;
  localparam logic [7:0] PORT3_RATE_LIMIT_CTRL_IDX = 8'h3B;
  localparam logic [7:0] PORT4_RATE_LIMIT_CTRL_IDX = 8'h4B;
  localparam logic [7:0] PORT5_RATE_LIMIT_CTRL_IDX = 8'h5B;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Field positions inside a control register
  localparam int BIT_RX_DIFF  = 7;
  localparam int BIT_RX_LO_EN = 6;
  localparam int BIT_RX_HI_EN = 5;
  localparam int BIT_RX_LO_FC = 4;
  localparam int BIT_RX_HI_FC = 3;
  localparam int BIT_TX_DIFF  = 2;
  localparam int BIT_TX_LO_EN = 1;
  localparam int BIT_TX_HI_EN = 0;

  // Per-port packet request from the classifier
  typedef struct packed {
    logic valid;
    logic high_prio;
  } prcs_pkt_t;

  // Per-port decision for one direction
  typedef struct packed {
    logic limit;
    logic use_high_rate;
  } prcs_sel_t;
endpackage

// [rtl/prcs_port_sel.sv]
`timescale 1ns/10ps
module prcs_port_sel
  import prcs_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                srst_i,
  input  wire logic [7:0]          ctrl_i,
  input  prcs_pkg::prcs_pkt_t      rx_pkt_i,
  input  prcs_pkg::prcs_pkt_t      tx_pkt_i,
  input  wire logic                rx_lo_exceed_i,
  input  wire logic                rx_hi_exceed_i,
  output prcs_pkg::prcs_sel_t      rx_sel_o,
  output prcs_pkg::prcs_sel_t      tx_sel_o,
  output logic                     fc_req_o
);
  logic rx_diff;
  logic tx_diff;
  prcs_sel_t rx_nxt;
  prcs_sel_t tx_nxt;
  logic fc_nxt;

  assign rx_diff = ctrl_i[BIT_RX_DIFF];
  assign tx_diff = ctrl_i[BIT_TX_DIFF];

  // Receive selection by class and mode
  always_comb
  begin
    rx_nxt = '0;
    if (rx_pkt_i.valid)
    begin
      if (!rx_diff)
      begin
        rx_nxt.limit = ctrl_i[BIT_RX_LO_EN];
        rx_nxt.use_high_rate = 1'b0;
      end
      else if (rx_pkt_i.high_prio)
      begin
        rx_nxt.limit = ctrl_i[BIT_RX_HI_EN];
        rx_nxt.use_high_rate = 1'b1;
      end
      else
      begin
        rx_nxt.limit = ctrl_i[BIT_RX_LO_EN];
        rx_nxt.use_high_rate = 1'b0;
      end
    end
  end

  // Transmit selection by class and mode
  always_comb
  begin
    tx_nxt = '0;
    if (tx_pkt_i.valid)
    begin
      if (tx_diff && tx_pkt_i.high_prio)
      begin
        tx_nxt.limit = ctrl_i[BIT_TX_HI_EN];
        tx_nxt.use_high_rate = 1'b1;
      end
      else
      begin
        tx_nxt.limit = ctrl_i[BIT_TX_LO_EN];
        tx_nxt.use_high_rate = 1'b0;
      end
    end
  end

  // Rate-based flow control request
  always_comb
  begin
    fc_nxt = (rx_lo_exceed_i && ctrl_i[BIT_RX_LO_FC])
           | (rx_hi_exceed_i && ctrl_i[BIT_RX_HI_FC] && rx_diff);
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      rx_sel_o <= '0;
      tx_sel_o <= '0;
      fc_req_o <= 1'b0;
    end
    else
    begin
      rx_sel_o <= rx_nxt;
      tx_sel_o <= tx_nxt;
      fc_req_o <= fc_nxt;
    end
  end

  // Flow control follows its enables one cycle later
  fc_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ((!rx_lo_exceed_i || !ctrl_i[BIT_RX_LO_FC]) && !(rx_hi_exceed_i && ctrl_i[BIT_RX_HI_FC])) |=> !fc_req_o)
    else $error("flow control without an enabled cause");
  fc_lo_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rx_lo_exceed_i && ctrl_i[BIT_RX_LO_FC]) |=> fc_req_o)
    else $error("low rate flow control missing");
  fc_hi_diff_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rx_hi_exceed_i && !rx_lo_exceed_i && !rx_diff) |=> !fc_req_o)
    else $error("high flow control without diff mode");
  rx_nodiff_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rx_pkt_i.valid && !rx_diff) |=> !rx_sel_o.use_high_rate)
    else $error("high rate used without rx diff");
  rx_hi_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rx_pkt_i.valid && rx_diff && rx_pkt_i.high_prio) |=>
      rx_sel_o.use_high_rate && rx_sel_o.limit == $past(ctrl_i[BIT_RX_HI_EN]))
    else $error("rx high selection wrong");
  rx_lo_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (rx_pkt_i.valid && (!rx_diff || !rx_pkt_i.high_prio)) |=>
      rx_sel_o.limit == $past(ctrl_i[BIT_RX_LO_EN]))
    else $error("rx low limiting wrong");
  tx_hi_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tx_pkt_i.valid && tx_diff && tx_pkt_i.high_prio) |=>
      tx_sel_o.use_high_rate && tx_sel_o.limit == $past(ctrl_i[BIT_TX_HI_EN]))
    else $error("tx high selection wrong");
  tx_lo_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (tx_pkt_i.valid && !(tx_diff && tx_pkt_i.high_prio)) |=>
      !tx_sel_o.use_high_rate && tx_sel_o.limit == $past(ctrl_i[BIT_TX_LO_EN]))
    else $error("tx low selection wrong");
  idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!rx_pkt_i.valid && !tx_pkt_i.valid) |=> !rx_sel_o.limit && !tx_sel_o.limit)
    else $error("limit without packet");
endmodule

// [rtl/prcs_top.sv]
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module prcs_top
  import prcs_pkg::*;
#(
  parameter int NPORT = prcs_pkg::NUM_PORTS
)
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        srst_i,
  // AXI4-Lite slave
  input  wire logic [prcs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [31:0]                 s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  output logic [1:0]                       s_axi_bresp_o,
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  input  wire logic [prcs_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  output logic [31:0]                      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i,
  // Frame path side, one entry per port
  input  prcs_pkg::prcs_pkt_t [NPORT-1:0]  rx_pkt_i,
  input  prcs_pkg::prcs_pkt_t [NPORT-1:0]  tx_pkt_i,
  input  wire logic [NPORT-1:0]            rx_lo_exceed_i,
  input  wire logic [NPORT-1:0]            rx_hi_exceed_i,
  output prcs_pkg::prcs_sel_t [NPORT-1:0]  rx_sel_o,
  output prcs_pkg::prcs_sel_t [NPORT-1:0]  tx_sel_o,
  output logic [NPORT-1:0]                 fc_req_o,
  output logic [NPORT-1:0][7:0]            ctrl_o
);
  // Byte address of each control word, four times its index
  localparam logic [AXI_ADDR_W-1:0] ADDR_TBL [5] = '{{PORT1_RATE_LIMIT_CTRL_IDX, 2'b00},
                                                     {PORT2_RATE_LIMIT_CTRL_IDX, 2'b00},
                                                     {PORT3_RATE_LIMIT_CTRL_IDX, 2'b00},
                                                     {PORT4_RATE_LIMIT_CTRL_IDX, 2'b00},
                                                     {PORT5_RATE_LIMIT_CTRL_IDX, 2'b00}};

  logic [NPORT-1:0][7:0] ctrl_r;
  logic [AXI_ADDR_W-1:0] aw_r;
  logic                  aw_have_r;
  logic [7:0]            wd_r;
  logic                  wd_strb_r;
  logic                  wd_have_r;
  logic                  do_write;
  logic [NPORT-1:0]      wsel;
  logic [NPORT-1:0]      rsel;
  logic                  w_hit;
  logic                  r_hit;
  logic [7:0]            rd_nxt;

  // Address decode for pending write and new read
  always_comb
  begin
    wsel = '0;
    rsel = '0;
    for (int p = 0; p < NPORT; p++)
    begin
      wsel[p] = (aw_r == ADDR_TBL[p]);
      rsel[p] = (s_axi_araddr_i == ADDR_TBL[p]);
    end
    w_hit = |wsel;
    r_hit = |rsel;
    rd_nxt = 8'h00;
    for (int p = 0; p < NPORT; p++)
      if (rsel[p])
        rd_nxt = ctrl_r[p];
  end

  assign do_write = aw_have_r && wd_have_r && !s_axi_bvalid_o;

  // Write address capture
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      aw_have_r <= 1'b0;
      aw_r <= '0;
      s_axi_awready_o <= 1'b0;
    end
    else
    begin
      s_axi_awready_o <= !aw_have_r && !s_axi_awready_o && s_axi_awvalid_i;
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_r <= 1'b1;
        aw_r <= s_axi_awaddr_i;
      end
      else if (do_write)
        aw_have_r <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      wd_have_r <= 1'b0;
      wd_r <= 8'h00;
      wd_strb_r <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end
    else
    begin
      s_axi_wready_o <= !wd_have_r && !s_axi_wready_o && s_axi_wvalid_i;
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        wd_have_r <= 1'b1;
        wd_r <= s_axi_wdata_i[7:0];
        wd_strb_r <= s_axi_wstrb_i[0];
      end
      else if (do_write)
        wd_have_r <= 1'b0;
    end
  end

  // Control registers, cleared by reset
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      ctrl_r <= {NPORT{CTRL_RESET}};
    else if (do_write && wd_strb_r)
    begin
      for (int p = 0; p < NPORT; p++)
        if (wsel[p])
          ctrl_r[p] <= wd_r;
    end
  end

  // Write response
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= w_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // Read channel
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o && s_axi_arvalid_i;
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= {24'h00_0000, rd_nxt};
        s_axi_rresp_o <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // Control mirror toward rate counters
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      ctrl_o <= {NPORT{CTRL_RESET}};
    else
      ctrl_o <= ctrl_r;
  end

  // One selector per port
  for (genvar g = 0; g < NPORT; g++)
  begin : g_port
    prcs_port_sel u_sel (
      .clk_sys_i      (clk_sys_i),
      .srst_i         (srst_i),
      .ctrl_i         (ctrl_r[g]),
      .rx_pkt_i       (rx_pkt_i[g]),
      .tx_pkt_i       (tx_pkt_i[g]),
      .rx_lo_exceed_i (rx_lo_exceed_i[g]),
      .rx_hi_exceed_i (rx_hi_exceed_i[g]),
      .rx_sel_o       (rx_sel_o[g]),
      .tx_sel_o       (tx_sel_o[g]),
      .fc_req_o       (fc_req_o[g])
    );
  end

  // Reset leaves every control bit cleared
  reset_clear_a: assert property (@(posedge clk_sys_i)
    srst_i |=> ctrl_r == '0)
    else $error("control not cleared by reset");
  // Write reaches the register the cycle after it is issued
  write_lands_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (do_write && wd_strb_r && wsel[0]) |=> ctrl_r[0] == $past(wd_r))
    else $error("write not stored");
  bresp_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    do_write |=> s_axi_bvalid_o)
    else $error("no write response");
  // Unmapped or unstrobed write leaves every register alone
  wr_ignored_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (do_write && (!w_hit || !wd_strb_r)) |=> $stable(ctrl_r))
    else $error("ignored write changed a register");
  // Answers stand until the master takes them
  bvalid_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (s_axi_rvalid_o && !s_axi_rready_i) |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  // Only the low byte of a read carries register bits
  rdata_upper_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");
endmodule

// [tb/tb_port_rate_control_select.sv]
`timescale 1ns/10ps
// Compare and count one value
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_port_rate_control_select;
  import prcs_pkg::*;
  localparam logic [AXI_ADDR_W-1:0] PADDR [NUM_PORTS] = '{{PORT1_RATE_LIMIT_CTRL_IDX, 2'b00},
    {PORT2_RATE_LIMIT_CTRL_IDX, 2'b00}, {PORT3_RATE_LIMIT_CTRL_IDX, 2'b00},
    {PORT4_RATE_LIMIT_CTRL_IDX, 2'b00}, {PORT5_RATE_LIMIT_CTRL_IDX, 2'b00}};
  logic                            clk_sys_i;
  logic                            srst_i;
  logic [AXI_ADDR_W-1:0]           awaddr;
  logic [AXI_ADDR_W-1:0]           araddr;
  logic                            awvalid, wvalid, bready, arvalid, rready;
  logic                            awready, wready, bvalid, arready, rvalid;
  logic [31:0]                     wdata, rdata, rd;
  logic [3:0]                      wstrb;
  logic [1:0]                      bresp, rresp, rs;
  prcs_pkt_t [NUM_PORTS-1:0]       rx_pkt, tx_pkt;
  prcs_sel_t [NUM_PORTS-1:0]       rx_sel, tx_sel;
  logic [NUM_PORTS-1:0]            lo_ex, hi_ex, fc;
  logic [NUM_PORTS-1:0][7:0]       ctrl;
  int                              mismatches, tests_run, cycles;

  prcs_top prcs_top_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_pkt_i(rx_pkt), .tx_pkt_i(tx_pkt), .rx_lo_exceed_i(lo_ex), .rx_hi_exceed_i(hi_ex),
    .rx_sel_o(rx_sel), .tx_sel_o(tx_sel), .fc_req_o(fc), .ctrl_o(ctrl));

  // Clock generator
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Verdict and end of run
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  // Write address and data together, then wait for the response
  task automatic axi_write(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_sys_i);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk_sys_i);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Single read
  task automatic axi_read(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk_sys_i);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Register defaults after reset
  task automatic test_reset();
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      axi_read(PADDR[p], rd, rs);
      `CHK("reset value", 32'h0, rd)
      `CHK("ctrl out", 8'h00, ctrl[p])
    end
    `CHK("fc idle", 5'h00, fc)
    $display("test_reset done");
  endtask

  // Read back, strobe, upper bits and unmapped access
  task automatic test_regs();
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      axi_write(PADDR[p], 32'hFFFF_FF00 | (8'h5A + p), 4'hF, rs);
      axi_write(PADDR[p], 32'h0000_00FF, 4'h0, rs);
      `CHK("strobe resp", RESP_OKAY, rs)
      axi_read(PADDR[p], rd, rs);
      `CHK("readback", 32'h5A + p, rd)
      @(posedge clk_sys_i);
      #1;
      `CHK("ctrl copy", 8'(8'h5A + p), ctrl[p])
    end
    axi_write(10'h000, 32'h0000_00FF, 4'hF, rs);
    `CHK("unmapped wr", RESP_SLVERR, rs)
    axi_read(10'h000, rd, rs);
    `CHK("unmapped rd", RESP_SLVERR, rs)
    `CHK("unmapped data", 32'h0, rd)
    $display("test_regs done");
  endtask

  // Expected selection from diff, low and high enables and class
  function automatic prcs_sel_t exp_sel(input logic df, input logic lo, input logic hi, input logic hp);
    exp_sel.limit = (df && hp) ? hi : lo;
    exp_sel.use_high_rate = df && hp;
  endfunction

  // Every enable combination for both classes, receive or transmit
  task automatic test_sel(input bit tx);
    prcs_sel_t e;
    prcs_sel_t g;
    int p;
    for (int c = 0; c < 16; c++)
    begin
      p = c % NUM_PORTS;
      axi_write(PADDR[p], tx ? {29'h0, c[2:0]} : {24'h0, c[2:0], 5'h00}, 4'hF, rs);
      rx_pkt[p] <= '{1'b1, c[3]};
      tx_pkt[p] <= '{1'b1, c[3]};
      repeat (2) @(posedge clk_sys_i);
      #1;
      e = exp_sel(c[2], c[1], c[0], c[3]);
      g = tx ? tx_sel[p] : rx_sel[p];
      `CHK("limit", e.limit, g.limit)
      `CHK("rate class", e.use_high_rate, g.use_high_rate)
    end
    $display("test_sel done dir %0d", tx);
  endtask

  // Flow control request against its enables and exceed inputs
  task automatic test_fc();
    int p;
    for (int c = 0; c < 8; c++)
    begin
      p = c % NUM_PORTS;
      axi_write(PADDR[p], {24'h0, c[2], 2'b00, c[1], c[0], 3'b000}, 4'hF, rs);
      for (int x = 0; x < 4; x++)
      begin
        lo_ex[p] <= x[0];
        hi_ex[p] <= x[1];
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK("fc req", (x[0] & c[1]) | (x[1] & c[0] & c[2]), fc[p])
      end
      lo_ex[p] <= 1'b0;
      hi_ex[p] <= 1'b0;
    end
    $display("test_fc done");
  endtask

  // Main sequence
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_pkt, tx_pkt, lo_ex, hi_ex} = '0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    srst_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    test_reset();
    test_regs();
    test_sel(1'b0);
    test_sel(1'b1);
    test_fc();
    print_verdict();
  end
endmodule
